// file: design/timer_ch4_ctrl.sv
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/10ps
`include "timer_ch4_consts.svh"

// How it works
// - Edge select 00 counts on rising edges of the selected count clock.
// - Edge select 01 counts on falling edges of the selected count clock.
// - In phase counting mode the edge selection is ignored.
// - Clear select 00 never clears; 01 clears on register A event.
// - Clear select 10 clears on register B match or capture.
// - Clear select 11 clears along with another synchronised channel.
// - Synchronous clearing acts only while the lockstep bit is one.
module timer_ch4_ctrl (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_clock_input_a,
    input wire logic ext_clock_input_c,
    input wire timer_ch4_pkg::chan_evt_t chanEvt,
    output logic [15:0] channel_up_counter,
    output logic clearOut
);
    import timer_ch4_pkg::*;

    function automatic logic mapped(input logic [15:0] a);
        mapped = (a == `CH4_CTRL_ADDR) || (a == `CH4_AUX_ADDR) ||
                 (a == `CH4_COUNT_ADDR);
    endfunction : mapped

    ctrl_t channel4_timer_control;
    ctrl_t next_ctrl;
    logic [1:0] auxReg;
    logic [1:0] next_auxReg;
    logic awHeld, next_awHeld, wHeld, next_wHeld;
    logic [15:0] awAddr, next_awAddr;
    logic [31:0] wData, next_wData;
    logic [3:0] wStrb, next_wStrb;
    logic next_bvalid, next_arready, next_rvalid, next_awready, next_wready;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic doWrite;
    logic countWrite;
    logic [15:0] countWdata;

    always_comb begin
        next_awHeld = awHeld;
        next_awAddr = awAddr;
        next_wHeld = wHeld;
        next_wData = wData;
        next_wStrb = wStrb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_arready = s_axi_arready;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        next_ctrl = channel4_timer_control;
        next_auxReg = auxReg;
        doWrite = awHeld && wHeld && !s_axi_bvalid;
        countWrite = 1'b0;
        countWdata = channel_up_counter;
        if (s_axi_awvalid && s_axi_awready) begin
            next_awHeld = 1'b1;
            next_awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_wHeld = 1'b1;
            next_wData = s_axi_wdata;
            next_wStrb = s_axi_wstrb;
        end
        if (doWrite) begin
            next_awHeld = 1'b0;
            next_wHeld = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = mapped(awAddr) ? `RESP_OKAY : `RESP_SLVERR;
            if (wStrb[0]) begin
                if (awAddr == `CH4_CTRL_ADDR) begin
                    // The top bit is reserved and always reads as zero.
                    next_ctrl = ctrl_t'({1'b0, wData[6:0]});
                end
                if (awAddr == `CH4_AUX_ADDR) begin
                    next_auxReg = wData[1:0];
                end
            end
            if (awAddr == `CH4_COUNT_ADDR && wStrb[1:0] != 2'b00) begin
                countWrite = 1'b1;
                countWdata[7:0] = wStrb[0] ? wData[7:0] : countWdata[7:0];
                countWdata[15:8] = wStrb[1] ? wData[15:8] : countWdata[15:8];
            end
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        next_awready = !next_awHeld && !next_bvalid;
        next_wready = !next_wHeld && !next_bvalid;
        if (s_axi_arvalid && s_axi_arready) begin
            next_arready = 1'b0;
            next_rvalid = 1'b1;
            next_rresp = mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
            case (s_axi_araddr)
                `CH4_CTRL_ADDR: next_rdata = {24'h000000,
                                              channel4_timer_control};
                `CH4_AUX_ADDR: next_rdata = {30'h00000000, auxReg};
                `CH4_COUNT_ADDR: next_rdata = {16'h0000, channel_up_counter};
                default: next_rdata = 32'h00000000;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
            next_arready = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            awHeld <= 1'b0;
            awAddr <= 16'h0000;
            wHeld <= 1'b0;
            wData <= 32'h00000000;
            wStrb <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
            channel4_timer_control <= ctrl_t'(`CH4_CTRL_RESET);
            auxReg <= `CH4_AUX_RESET;
        end else begin
            awHeld <= next_awHeld;
            awAddr <= next_awAddr;
            wHeld <= next_wHeld;
            wData <= next_wData;
            wStrb <= next_wStrb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            channel4_timer_control <= next_ctrl;
            auxReg <= next_auxReg;
        end
    end

    logic [`DIV_WIDTH-1:0] divCnt;
    logic prevLvl, srcLvl, edgeSel, srcRise, srcFall, tick, clearHit;
    logic lockstep, phaseMode;
    logic [`DIV_WIDTH-1:0] next_divCnt;
    logic [15:0] next_counter;
    logic next_clearOut;

    assign lockstep = auxReg[`AUX_LOCKSTEP_BIT];
    assign phaseMode = auxReg[`AUX_PHASE_BIT];

    always_comb begin
        next_divCnt = divCnt + `DIV_WIDTH'(1);
        edgeSel = 1'b1;
        case (channel4_timer_control.prescalerSelect)
            PS_DIV4: srcLvl = divCnt[`DIV_TAP4];
            PS_DIV16: srcLvl = divCnt[`DIV_TAP16];
            PS_DIV64: srcLvl = divCnt[`DIV_TAP64];
            PS_EXTA: srcLvl = ext_clock_input_a;
            PS_EXTC: srcLvl = ext_clock_input_c;
            PS_DIV1024: srcLvl = divCnt[`DIV_TAP1024];
            default: begin
                // Full rate and neighbour overflow are pulse sources.
                srcLvl = 1'b0;
                edgeSel = 1'b0;
            end
        endcase
        srcRise = srcLvl && !prevLvl;
        srcFall = !srcLvl && prevLvl;
        if (phaseMode) begin
            tick = chanEvt.phaseStep;
        end else if (!edgeSel) begin
            tick = (channel4_timer_control.prescalerSelect == PS_DIV1) ||
                   chanEvt.neighbourOverflow;
        end else if (channel4_timer_control.clockEdgeSelect[1]) begin
            tick = srcRise || srcFall;
        end else if (channel4_timer_control.clockEdgeSelect[0]) begin
            tick = srcFall;
        end else begin
            tick = srcRise;
        end
        case (channel4_timer_control.counterClearSelect)
            CLR_BY_A: clearHit = chanEvt.generalRegAEvent;
            CLR_BY_B: clearHit = chanEvt.generalRegBEvent;
            CLR_SYNC: clearHit = chanEvt.syncClearIn && lockstep;
            default: clearHit = 1'b0;
        endcase
        next_clearOut = clearHit && lockstep &&
            (channel4_timer_control.counterClearSelect != CLR_SYNC);
        // A software write wins, then a clear, then a count.
        if (countWrite) begin
            next_counter = countWdata;
        end else if (clearHit) begin
            next_counter = 16'h0000;
        end else if (tick) begin
            next_counter = channel_up_counter + 16'h0001;
        end else begin
            next_counter = channel_up_counter;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            divCnt <= '0;
            prevLvl <= 1'b0;
            channel_up_counter <= `CH4_COUNT_RESET;
            clearOut <= 1'b0;
        end else begin
            divCnt <= next_divCnt;
            prevLvl <= srcLvl;
            channel_up_counter <= next_counter;
            clearOut <= next_clearOut;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    edge_rise_a: assert property (
        !phaseMode && edgeSel && !countWrite && !clearHit && srcFall &&
        channel4_timer_control.clockEdgeSelect == 2'b00 |=>
        $stable(channel_up_counter)) else $error("falling edge counted");
    edge_fall_a: assert property (
        !phaseMode && edgeSel && !countWrite && !clearHit && srcRise &&
        channel4_timer_control.clockEdgeSelect == 2'b01 |=>
        $stable(channel_up_counter)) else $error("rising edge counted");
    edge_both_a: assert property (
        !phaseMode && edgeSel && !countWrite && !clearHit && srcFall &&
        channel4_timer_control.clockEdgeSelect[1] |=> channel_up_counter ==
        16'($past(channel_up_counter) + 16'h0001))
        else $error("both edge select miscounts");
    phase_ignore_a: assert property (
        phaseMode && !countWrite && !clearHit && chanEvt.phaseStep |=>
        channel_up_counter == 16'($past(channel_up_counter) + 16'h0001))
        else $error("phase step not counted");
    clear_a_a: assert property (
        channel4_timer_control.counterClearSelect == CLR_BY_A &&
        chanEvt.generalRegAEvent && !countWrite |=> channel_up_counter == 0)
        else $error("register A event did not clear");
    no_clear_a: assert property (
        channel4_timer_control.counterClearSelect == CLR_NONE &&
        !countWrite && !tick |=> $stable(channel_up_counter))
        else $error("counter changed with clearing disabled");
    clear_b_a: assert property (
        channel4_timer_control.counterClearSelect == CLR_BY_B &&
        chanEvt.generalRegBEvent && !countWrite |=> channel_up_counter == 0)
        else $error("register B event did not clear");
    sync_clear_a: assert property (
        channel4_timer_control.counterClearSelect == CLR_SYNC && lockstep &&
        chanEvt.syncClearIn && !countWrite |=> channel_up_counter == 0)
        else $error("synchronous clear missed");
    sync_gate_a: assert property (
        channel4_timer_control.counterClearSelect == CLR_SYNC && !lockstep &&
        !countWrite && tick |=>
        channel_up_counter == 16'($past(channel_up_counter) + 16'h0001))
        else $error("synchronous clear acted without lockstep");
    presc_tap_a: assert property (
        channel4_timer_control.prescalerSelect == PS_DIV1 && !phaseMode &&
        !countWrite && !clearHit |=> channel_up_counter ==
        16'($past(channel_up_counter) + 16'h0001))
        else $error("full rate prescaler miscounts");

    write_seen_c: cover property (doWrite && awAddr == `CH4_CTRL_ADDR);
    sync_seen_c: cover property (clearHit &&
        channel4_timer_control.counterClearSelect == CLR_SYNC);
    both_edge_c: cover property (tick && srcFall &&
        channel4_timer_control.clockEdgeSelect[1]);
endmodule : timer_ch4_ctrl

// file: design/timer_ch4_consts.svh
`ifndef TIMER_CH4_CONSTS_SVH
`define TIMER_CH4_CONSTS_SVH

// Byte addresses of the channel registers on the 16-bit address space.
`define CH4_CTRL_ADDR 16'hfe90
`define CH4_AUX_ADDR 16'hfe94
`define CH4_COUNT_ADDR 16'hfe98
`define CH4_CTRL_RESET 8'h00
`define CH4_AUX_RESET 2'h0
`define CH4_COUNT_RESET 16'h0000
// Field positions in the aux register.
`define AUX_LOCKSTEP_BIT 0
`define AUX_PHASE_BIT 1
// Divider taps: level period of 4, 16, 64 and 1024 system cycles.
`define DIV_TAP4 1
`define DIV_TAP16 3
`define DIV_TAP64 5
`define DIV_TAP1024 9
`define DIV_WIDTH 10
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: design/timer_ch4_pkg.sv
package timer_ch4_pkg;

    typedef enum logic [1:0] {
        CLR_NONE = 2'b00,
        CLR_BY_A = 2'b01,
        CLR_BY_B = 2'b10,
        CLR_SYNC = 2'b11
    } clear_sel_t;

    typedef enum logic [2:0] {
        PS_DIV1 = 3'b000,
        PS_DIV4 = 3'b001,
        PS_DIV16 = 3'b010,
        PS_DIV64 = 3'b011,
        PS_EXTA = 3'b100,
        PS_EXTC = 3'b101,
        PS_DIV1024 = 3'b110,
        PS_NEIGHBOUR = 3'b111
    } presc_sel_t;

    typedef struct packed {
        logic reserved;
        clear_sel_t counterClearSelect;
        logic [1:0] clockEdgeSelect;
        presc_sel_t prescalerSelect;
    } ctrl_t;

    typedef struct packed {
        logic generalRegAEvent;
        logic generalRegBEvent;
        logic syncClearIn;
        logic neighbourOverflow;
        logic phaseStep;
    } chan_evt_t;

endpackage : timer_ch4_pkg

// file: dv/tb.sv
`timescale 1ns/10ps
`include "timer_ch4_consts.svh"

module tb;
    import timer_ch4_pkg::*;
    logic clk_sys = 1'h0;
    logic rstn = 1'h0;
    logic [15:0] awaddr = 16'h0000;
    logic [15:0] araddr = 16'h0000;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic arvalid = 1'h0;
    logic [31:0] wdata = 32'h0;
    logic extA = 1'h0;
    logic extC = 1'h0;
    chan_evt_t chanEvt = chan_evt_t'(5'h00);
    logic awready, wready, bvalid, arready, rvalid, clearOut;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] count;
    logic [1:0] qw[$];
    logic [33:0] qr[$];
    logic [15:0] lfsr = 16'h003b;
    int nFail = 0;
    int checked = 0;
    int nClr = 0;

    timer_ch4_ctrl dut (
        .clk_sys(clk_sys), .rstn(rstn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'h1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(1'h1),
        .ext_clock_input_a(extA), .ext_clock_input_c(extC),
        .chanEvt(chanEvt), .channel_up_counter(count), .clearOut(clearOut)
    );

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nxt

    function automatic logic [31:0] ctl(input logic [1:0] c,
                                        input logic [1:0] e,
                                        input logic [2:0] p);
        return {25'h0, c, e, p};
    endfunction : ctl

    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        checked++;
        if (seen !== exp) begin
            nFail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic final_report();
        $display("checked=%0d failed=%0d", checked, nFail);
        if (nFail == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    // Responses are matched here, in order, against the notes of the driver.
    always @(posedge clk_sys) begin
        if (clearOut === 1'h1) nClr++;
        if (rstn && bvalid === 1'h1) chk(34'(bresp), 34'(qw.pop_front()));
        if (rstn && rvalid === 1'h1) chk({rresp, rdata}, qr.pop_front());
    end

    task automatic wr(input logic [15:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        int n;
        n = 0;
        qw.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        do begin
            @(posedge clk_sys);
            n++;
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
        end while (bvalid !== 1'h1 && n < 50);
        if (bvalid !== 1'h1) begin
            nFail++;
            final_report();
        end
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [33:0] exp);
        int n;
        n = 0;
        qr.push_back(exp);
        araddr <= a;
        arvalid <= 1'h1;
        do begin
            @(posedge clk_sys);
            n++;
            if (arready === 1'h1) arvalid <= 1'h0;
        end while (rvalid !== 1'h1 && n < 50);
        if (rvalid !== 1'h1) begin
            nFail++;
            final_report();
        end
    endtask : rd

    task automatic rc(input logic [15:0] exp);
        rd(`CH4_COUNT_ADDR, {18'h0, exp});
    endtask : rc

    // Pins are held for several cycles so the edge detector surely sees them.
    task automatic tog(input logic a, input logic c);
        extA <= a;
        extC <= c;
        repeat (4) @(posedge clk_sys);
        extA <= 1'h0;
        extC <= 1'h0;
        repeat (4) @(posedge clk_sys);
    endtask : tog

    task automatic evt(input logic [4:0] m);
        chanEvt <= chan_evt_t'(m);
        @(posedge clk_sys);
        chanEvt <= chan_evt_t'(5'h00);
        repeat (4) @(posedge clk_sys);
    endtask : evt

    initial begin
        int k;
        int e;
        int v;
        logic [2:0] p;
        repeat (16) @(posedge clk_sys);
        rstn <= 1'h1;
        @(posedge clk_sys);
        chk(34'({awready, wready, arready, bvalid, rvalid}), 34'h1c);
        rd(`CH4_CTRL_ADDR, 34'h0);
        rd(`CH4_AUX_ADDR, 34'h0);
        rd(16'hfe9c, {2'h2, 32'h0});
        lfsr = nxt(lfsr);
        wr(`CH4_CTRL_ADDR, {24'h0, 1'h1, lfsr[6:0]}, 2'h0);
        wr(16'hfe9c, 32'hff, 2'h2);
        rd(`CH4_CTRL_ADDR, {27'h0, lfsr[6:0]});
        for (e = 0; e < 4; e++) begin
            wr(`CH4_CTRL_ADDR, ctl(2'h0, e[1:0], PS_EXTA), 2'h0);
            lfsr = nxt(lfsr);
            wr(`CH4_COUNT_ADDR, {16'h0, lfsr}, 2'h0);
            tog(1'h1, 1'h0);
            rc(lfsr + (e[1] ? 16'h2 : 16'h1));
        end
        wr(`CH4_CTRL_ADDR, ctl(2'h0, 2'h0, PS_EXTC), 2'h0);
        wr(`CH4_COUNT_ADDR, 32'h0, 2'h0);
        tog(1'h1, 1'h0);
        rc(16'h0);
        tog(1'h0, 1'h1);
        rc(16'h1);
        wr(`CH4_CTRL_ADDR, ctl(2'h0, 2'h1, PS_NEIGHBOUR), 2'h0);
        wr(`CH4_COUNT_ADDR, 32'h0, 2'h0);
        repeat (3) evt(5'h02);
        rc(16'h3);
        // A 1024-edge window holds exactly 1024/period ticks of each tap.
        for (k = 0; k < 5; k++) begin
            p = (k == 4) ? PS_DIV1024 : 3'(k);
            wr(`CH4_CTRL_ADDR, ctl(2'h0, 2'h0, p), 2'h0);
            wr(`CH4_COUNT_ADDR, 32'h0, 2'h0);
            repeat (1023) @(posedge clk_sys);
            rc((k == 4) ? 16'h1 : 16'(1024 >> (2 * k)));
        end
        wr(`CH4_AUX_ADDR, 32'h2, 2'h0);
        wr(`CH4_CTRL_ADDR, ctl(2'h0, 2'h1, PS_EXTA), 2'h0);
        wr(`CH4_COUNT_ADDR, 32'h0, 2'h0);
        repeat (2) evt(5'h01);
        // Pin edges must not count while phase counting is on.
        tog(1'h1, 1'h0);
        rc(16'h2);
        wr(`CH4_AUX_ADDR, 32'h1, 2'h0);
        for (k = 0; k < 4; k++) begin
            wr(`CH4_CTRL_ADDR, ctl(k[1:0], 2'h0, PS_EXTA), 2'h0);
            for (e = 0; e < 3; e++) begin
                wr(`CH4_COUNT_ADDR, 32'h5, 2'h0);
                v = nClr;
                evt(5'(5'h10 >> e));
                rc((k == e + 1) ? 16'h0 : 16'h5);
                chk(34'(nClr - v), (k == e + 1 && k < 3) ? 34'h1 : 34'h0);
            end
        end
        wr(`CH4_AUX_ADDR, 32'h0, 2'h0);
        wr(`CH4_COUNT_ADDR, 32'h5, 2'h0);
        evt(5'h04);
        rc(16'h5);
        chk(34'(count), 34'h5);
        final_report();
    end
endmodule : tb
